// ### hdl/cmav_pkg.sv
// package: modes, request kinds, address masks and vector layout for the mode address logic
package cmav_pkg;

  // ****************************************************************
  // operating modes, as strapped on the mode pins
  // ****************************************************************
  typedef enum logic [1:0] {
    CMAV_MODE_NORMAL   = 2'h0,
    CMAV_MODE_MIDDLE   = 2'h1,
    CMAV_MODE_ADVANCED = 2'h2,
    CMAV_MODE_MAXIMUM  = 2'h3
  } cmav_mode_t;

  // ****************************************************************
  // request kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    CMAV_K_DATA_EA   = 3'h0,  // data effective address
    CMAV_K_PROG_EA   = 3'h1,  // program address, register jump target
    CMAV_K_VEC_ADDR  = 3'h2,  // vector number to table entry address
    CMAV_K_IND_ADDR  = 3'h3,  // 8-bit absolute to indirect operand address
    CMAV_K_VEC_TGT   = 3'h4,  // vector entry read data to branch target
    CMAV_K_IND_TGT   = 3'h5,  // indirect operand read data to branch target
    CMAV_K_STACK_PC  = 3'h6,  // pc to stacked image
    CMAV_K_PTR_STEP  = 3'h7   // pointer pre/post increment or decrement
  } cmav_kind_t;

  // aux field layout
  localparam int unsigned CMAV_AUX_VEC_LSB  = 0;   // vector number, 7 bits
  localparam int unsigned CMAV_AUX_VEC_W    = 7;
  localparam int unsigned CMAV_AUX_STEP_LSB = 0;   // step in bytes, 3 bits
  localparam int unsigned CMAV_AUX_STEP_W   = 3;
  localparam int unsigned CMAV_AUX_DEC_BIT  = 3;   // 1 = decrement
  localparam int unsigned CMAV_AUX_EXC_BIT  = 0;   // stack push is exception entry
  localparam int unsigned CMAV_AUX_USE_BIT  = 1;   // extended control reg in use

  typedef struct packed {
    cmav_kind_t  kind;
    logic [31:0] value;
    logic [7:0]  aux;
  } cmav_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0]  pc_bytes;   // stacked pc size, stack pushes only
    logic        push_ext_ctl;  // extended control reg goes on the stack too
  } cmav_res_t;

  // ****************************************************************
  // address masks, vector table and stack sizes
  // ****************************************************************
  localparam logic [31:0] CMAV_MASK_16   = 32'h0000_FFFF;
  localparam logic [31:0] CMAV_MASK_24   = 32'h00FF_FFFF;
  localparam logic [31:0] CMAV_MASK_32   = 32'hFFFF_FFFF;
  localparam logic [31:0] CMAV_VEC_BASE  = 32'h0000_0000;
  localparam int unsigned CMAV_VEC_SH_16 = 1;
  localparam int unsigned CMAV_VEC_SH_32 = 2;
  localparam logic [2:0]  CMAV_PC_B_16   = 3'h2;
  localparam logic [2:0]  CMAV_PC_B_24   = 3'h3;
  localparam logic [2:0]  CMAV_PC_B_32   = 3'h4;

endpackage : cmav_pkg

// ### hdl/cmav_core.sv
// mode-dependent address, vector and stack width logic of the cpu core
//
// How it works
// (R01) normal mode reaches only 64 kbytes
// (R02) normal mode keeps low 16 address bits
// (R03) normal vectors at zero, 16-bit entries
// (R04) pointer step carry reaches extended half
// (R05) normal mode stacks pc as 16 bits
// (R06) middle: 16M program, 64K data
// (R07) middle data address sign-extends bit 15
// (R08) middle jumps use extended half too
// (R09) middle vectors 32-bit, low 24 used
// (R10) indirect operand at 8-bit absolute address
// (R11) middle indirect operand top byte zero
// (R12) middle/advanced stack pc as 24 bits
// (R13) advanced: 16M program, 4G data
// (R14) advanced/maximum extended half is upper half
// (R15) advanced vectors 32-bit, low 24 used
// (R16) advanced indirect operand top byte zero
// (R17) maximum: 4G program and data
// (R18) maximum vectors hold full 32 bits
// (R19) maximum indirect operand full 32 bits
// (R20) maximum stacks 32-bit pc plus extended control
// (R21) fetch width select, data unaffected
// (R22) software matches fetch width to code bus
// (R23) only advanced mode exists on this part
// (R24) mode latched at reset, then held
`timescale 1ns/1ns
`default_nettype none

module cmav_core
  import cmav_pkg::*;
#(
  parameter bit ADVANCED_ONLY = 1'b1
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic [1:0] mode_pins_i,
  input  wire logic       fetch_width_select_i,
  input  wire logic       req_valid_i,
  input  wire cmav_req_t  req_i,
  output logic            ready_o,
  output logic            res_valid_o,
  output cmav_res_t       res_o,
  output cmav_mode_t      mode_o,
  output logic            mode_unsupported_o,
  output logic            fetch_wide_o
);

  // ****************************************************************
  // mode latch sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    CMAV_ST_RESET = 2'h0,
    CMAV_ST_LATCH = 2'h1,
    CMAV_ST_RUN   = 2'h3
  } cmav_state_t;

  cmav_state_t state_reg;
  cmav_state_t state_next;
  cmav_mode_t  mode_reg;
  logic        unsup_reg;
  logic        fetch_reg;
  logic        ready_reg;
  logic        res_valid_reg;
  cmav_res_t   res_reg;
  cmav_res_t   res_next;
  logic        take;

  always_comb begin
    case (state_reg)
      CMAV_ST_RESET: state_next = CMAV_ST_LATCH;
      CMAV_ST_LATCH: state_next = CMAV_ST_RUN;
      CMAV_ST_RUN:   state_next = CMAV_ST_RUN;
      default:       state_next = CMAV_ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= CMAV_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // the strap is caught once, on the second edge after release, so the pins may settle
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_reg  <= CMAV_MODE_ADVANCED;
      unsup_reg <= 1'b0;
    end else if (state_reg == CMAV_ST_LATCH) begin  // R24
      if (ADVANCED_ONLY && mode_pins_i != CMAV_MODE_ADVANCED) begin
        // a strap for a missing mode falls back to advanced and is flagged
        mode_reg  <= CMAV_MODE_ADVANCED;  // R23
        unsup_reg <= 1'b1;  // R23
      end else begin
        mode_reg  <= cmav_mode_t'(mode_pins_i);  // R24
        unsup_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == CMAV_ST_RUN);
    end
  end

  // fetch width only steers instruction fetch; no data path reads it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= fetch_width_select_i;  // R21
    end
  end

  // ****************************************************************
  // mode dependent address formation
  // ****************************************************************
  assign take = req_valid_i && ready_reg;

  always_comb begin
    logic [31:0] v;
    logic [31:0] step;
    logic [6:0]  vnum;
    v        = req_i.value;
    step     = {29'h0, req_i.aux[CMAV_AUX_STEP_LSB +: CMAV_AUX_STEP_W]};
    vnum     = req_i.aux[CMAV_AUX_VEC_LSB +: CMAV_AUX_VEC_W];
    res_next = '0;
    case (req_i.kind)
      CMAV_K_DATA_EA: begin
        case (mode_reg)
          CMAV_MODE_NORMAL: res_next.addr = v & CMAV_MASK_16;  // R01 R02
          CMAV_MODE_MIDDLE: begin
            // data lives in 64 kbytes folded to both ends of the 16M space
            res_next.addr = {8'h00, {8{v[15]}}, v[15:0]};  // R06 R07
          end
          default:          res_next.addr = v;  // R13 R14 R17
        endcase
      end
      CMAV_K_PROG_EA: begin
        case (mode_reg)
          CMAV_MODE_NORMAL:  res_next.addr = v & CMAV_MASK_16;  // R01
          CMAV_MODE_MAXIMUM: res_next.addr = v & CMAV_MASK_32;  // R17
          // the extended half is not free here: it supplies target bits 23:16
          default:           res_next.addr = v & CMAV_MASK_24;  // R06 R08 R13
        endcase
      end
      CMAV_K_VEC_ADDR: begin
        if (mode_reg == CMAV_MODE_NORMAL) begin
          res_next.addr = CMAV_VEC_BASE + ({25'h0, vnum} << CMAV_VEC_SH_16);  // R03
        end else begin
          res_next.addr = CMAV_VEC_BASE + ({25'h0, vnum} << CMAV_VEC_SH_32);  // R09 R15 R18
        end
      end
      CMAV_K_IND_ADDR: begin
        res_next.addr = {24'h00_0000, req_i.aux};  // R10
      end
      CMAV_K_VEC_TGT, CMAV_K_IND_TGT: begin
        case (mode_reg)
          CMAV_MODE_NORMAL:  res_next.addr = v & CMAV_MASK_16;  // R03
          CMAV_MODE_MAXIMUM: res_next.addr = v;  // R18 R19
          // top byte ignored in the table, reserved zero in the operand
          default:           res_next.addr = v & CMAV_MASK_24;  // R09 R11 R15 R16
        endcase
      end
      CMAV_K_STACK_PC: begin
        case (mode_reg)
          CMAV_MODE_NORMAL: begin
            res_next.addr     = v & CMAV_MASK_16;  // R05
            res_next.pc_bytes = CMAV_PC_B_16;  // R05
            res_next.push_ext_ctl = req_i.aux[CMAV_AUX_EXC_BIT] && req_i.aux[CMAV_AUX_USE_BIT];
          end
          CMAV_MODE_MAXIMUM: begin
            res_next.addr     = v;  // R20
            res_next.pc_bytes = CMAV_PC_B_32;  // R20
            // stacked on every exception, in use or not, so frames are uniform
            res_next.push_ext_ctl = req_i.aux[CMAV_AUX_EXC_BIT];  // R20
          end
          default: begin
            res_next.addr     = v & CMAV_MASK_24;  // R12
            res_next.pc_bytes = CMAV_PC_B_24;  // R12
            res_next.push_ext_ctl = req_i.aux[CMAV_AUX_EXC_BIT] && req_i.aux[CMAV_AUX_USE_BIT];
          end
        endcase
      end
      CMAV_K_PTR_STEP: begin
        // full 32-bit add, so a carry out of the low half lands in the extended half
        if (req_i.aux[CMAV_AUX_DEC_BIT]) begin
          res_next.addr = v - step;  // R04 R14
        end else begin
          res_next.addr = v + step;  // R04 R14
        end
      end
      default: res_next = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      res_valid_reg <= 1'b0;
      res_reg       <= '0;
    end else begin
      res_valid_reg <= take;
      if (take) begin
        res_reg <= res_next;
      end
    end
  end

  assign ready_o            = ready_reg;
  assign res_valid_o        = res_valid_reg;
  assign res_o              = res_reg;
  assign mode_o             = mode_reg;
  assign mode_unsupported_o = unsup_reg;
  assign fetch_wide_o       = fetch_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_take(cmav_kind_t k);
    req_valid_i && ready_reg && req_i.kind == k;
  endsequence

  sequence s_answer;
    res_valid_reg;
  endsequence

  sequence s_take_in(cmav_kind_t k, cmav_mode_t m);
    s_take(k) ##0 mode_reg == m;
  endsequence

  mode_held_a: assert property (ready_reg |=> $stable(mode_reg))  // R24
    else $error("mode changed after latch");

  adv_only_a: assert property (ready_reg |-> (!ADVANCED_ONLY                 // R23
                                             || mode_reg == CMAV_MODE_ADVANCED))
    else $error("unsupported mode active");

  ready_seq_a: assert property ($fell(reset_i) |-> !ready_reg ##2 ready_reg)  // R24
    else $error("ready not raised two edges after release");

  mid_data_ea_a: assert property (s_take_in(CMAV_K_DATA_EA, CMAV_MODE_MIDDLE)  // R07
      |=> s_answer ##0 res_reg.addr == {8'h00, {8{$past(req_i.value[15])}},
                                         $past(req_i.value[15:0])})
    else $error("middle data address not sign-extended");

  norm_ea_a: assert property (s_take_in(CMAV_K_DATA_EA, CMAV_MODE_NORMAL)  // R02
      |=> res_reg.addr == {16'h0000, $past(req_i.value[15:0])})
    else $error("normal address not truncated");

  vec_addr_a: assert property (s_take(CMAV_K_VEC_ADDR) ##0 mode_reg != CMAV_MODE_NORMAL // R09
      |=> res_reg.addr == {23'h0, $past(req_i.aux[6:0]), 2'h0})
    else $error("vector entry address wrong");

  ind_addr_a: assert property (s_take(CMAV_K_IND_ADDR)  // R10
      |=> s_answer ##0 res_reg.addr[31:8] == 24'h00_0000
          ##0 res_reg.addr[7:0] == $past(req_i.aux))
    else $error("indirect operand address wrong");

  adv_target_a: assert property (s_take_in(CMAV_K_IND_TGT, CMAV_MODE_ADVANCED)  // R16
      |=> res_reg.addr == {8'h00, $past(req_i.value[23:0])})
    else $error("advanced indirect target top byte not zero");

  stack_width_a: assert property (s_take(CMAV_K_STACK_PC)  // R12
      |=> res_reg.pc_bytes == (mode_reg == CMAV_MODE_NORMAL  ? CMAV_PC_B_16 :
                               mode_reg == CMAV_MODE_MAXIMUM ? CMAV_PC_B_32 : CMAV_PC_B_24))
    else $error("stacked pc width wrong");

  max_ext_ctl_a: assert property (s_take_in(CMAV_K_STACK_PC, CMAV_MODE_MAXIMUM)  // R20
      ##0 req_i.aux[CMAV_AUX_EXC_BIT] |=> res_reg.push_ext_ctl)
    else $error("extended control not stacked");

  ptr_carry_a: assert property (s_take(CMAV_K_PTR_STEP) ##0 (!req_i.aux[CMAV_AUX_DEC_BIT] // R04
      && req_i.value[15:0] == 16'hFFFF && req_i.aux[2:0] != 3'h0)
      |=> res_reg.addr[31:16] == $past(req_i.value[31:16]) + 16'h0001)
    else $error("pointer carry lost");

  ptr_borrow_a: assert property (s_take(CMAV_K_PTR_STEP)  // R04
      ##0 (req_i.aux[CMAV_AUX_DEC_BIT] && req_i.value[15:0] == 16'h0000
           && req_i.aux[2:0] != 3'h0)
      |=> res_reg.addr[31:16] == $past(req_i.value[31:16]) - 16'h0001)
    else $error("pointer borrow lost");

  norm_prog_a: assert property (s_take_in(CMAV_K_PROG_EA, CMAV_MODE_NORMAL)  // R01
      |=> res_reg.addr[31:16] == 16'h0000)
    else $error("normal program address beyond 64 kbytes");

  norm_vec_a: assert property (s_take_in(CMAV_K_VEC_ADDR, CMAV_MODE_NORMAL)  // R03
      |=> res_reg.addr == {24'h00_0000, $past(req_i.aux[6:0]), 1'b0})
    else $error("normal vector entry address wrong");

  norm_stack_a: assert property (s_take_in(CMAV_K_STACK_PC, CMAV_MODE_NORMAL)  // R05
      |=> res_reg.addr == {16'h0000, $past(req_i.value[15:0])})
    else $error("normal stacked pc not 16 bits");

  mid_prog_a: assert property (s_take_in(CMAV_K_PROG_EA, CMAV_MODE_MIDDLE)  // R08
      |=> res_reg.addr == {8'h00, $past(req_i.value[23:0])})
    else $error("middle jump target lost extended half");

  mid_table_a: assert property (s_take_in(CMAV_K_VEC_TGT, CMAV_MODE_MIDDLE)  // R09
      |=> res_reg.addr == {8'h00, $past(req_i.value[23:0])})
    else $error("middle vector target not 24 bits");

  mid_ind_tgt_a: assert property (s_take_in(CMAV_K_IND_TGT, CMAV_MODE_MIDDLE)  // R11
      |=> res_reg.addr == {8'h00, $past(req_i.value[23:0])})
    else $error("middle indirect target top byte not zero");

  adv_data_a: assert property (s_take_in(CMAV_K_DATA_EA, CMAV_MODE_ADVANCED)  // R13
      |=> res_reg.addr == $past(req_i.value))
    else $error("advanced data address not linear");

  adv_table_a: assert property (s_take_in(CMAV_K_VEC_TGT, CMAV_MODE_ADVANCED)  // R15
      |=> res_reg.addr == {8'h00, $past(req_i.value[23:0])})
    else $error("advanced vector target not 24 bits");

  max_prog_a: assert property (s_take_in(CMAV_K_PROG_EA, CMAV_MODE_MAXIMUM)  // R17
      |=> res_reg.addr == $past(req_i.value))
    else $error("maximum program address cut");

  max_table_a: assert property (s_take_in(CMAV_K_VEC_TGT, CMAV_MODE_MAXIMUM)  // R18
      |=> res_reg.addr == $past(req_i.value))
    else $error("maximum vector target cut");

  max_ind_a: assert property (s_take_in(CMAV_K_IND_TGT, CMAV_MODE_MAXIMUM)  // R19
      |=> res_reg.addr == $past(req_i.value))
    else $error("maximum indirect target cut");

  max_stack_a: assert property (s_take_in(CMAV_K_STACK_PC, CMAV_MODE_MAXIMUM)  // R20
      |=> res_reg.addr == $past(req_i.value))
    else $error("maximum stacked pc cut");

  ext_ctl_idle_a: assert property (s_take(CMAV_K_STACK_PC)  // R20
      ##0 (mode_reg != CMAV_MODE_MAXIMUM && !req_i.aux[CMAV_AUX_USE_BIT])
      |=> !res_reg.push_ext_ctl)
    else $error("extended control stacked while unused");

  refuse_a: assert property (!ready_reg |=> !res_valid_reg)  // R24
    else $error("answer while not ready");

  answer_once_a: assert property (s_answer |-> $past(req_valid_i && ready_reg))  // R21
    else $error("answer without request");

  fetch_follow_a: assert property (1'b1 |=> fetch_wide_o == $past(fetch_width_select_i)) // R21
    else $error("fetch width not followed");

endmodule : cmav_core

`default_nettype wire

// ### bench/cmav_mem_model.sv
// memory bus model holding the vector table and indirect branch operands
`timescale 1ns/1ns
`default_nettype none

module cmav_mem_model #(
  parameter int CODE_BUS_W = 32
) (
  input  wire logic        rd_en_i,
  input  wire logic [31:0] addr_i,
  output var  logic [31:0] rd_data_o
);
  // top byte carries junk so the core must drop it where only 24 bits count
  // a released bus inverts its value on each release or address change, so two such events show a stale copy
  always @(rd_en_i or addr_i) begin
    if (rd_en_i) begin
      rd_data_o = {addr_i[9:2] ^ 8'hC3, addr_i[23:0] ^ 24'h5A_0F3C};
    end else begin
      rd_data_o = ~rd_data_o;
    end
  end
endmodule : cmav_mem_model
`default_nettype wire

// ### bench/cmav_core_tb.sv
// self-checking bench for the mode address, vector and stack logic
`timescale 1ns/1ns
`default_nettype none

module cmav_core_tb;
  import cmav_pkg::*;
  localparam int CODE_BUS_W = 32;
  logic        core_clk_i, reset_i, fetch_width_select_i, req_valid_i;
  logic [1:0]  mode_pins_i;
  cmav_req_t   req_i;
  logic        ready_o, res_valid_o, mode_unsupported_o, fetch_wide_o, adv_unsup;
  cmav_res_t   res_o, last_exp;
  cmav_mode_t  mode_o, adv_mode;
  logic        mem_en;
  logic [31:0] mem_addr, mem_data, seed;
  int          fails, checked;

  // ****************************************************************
  // clock and instances
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  cmav_core #(.ADVANCED_ONLY(1'b0)) u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .mode_pins_i(mode_pins_i), .fetch_width_select_i(fetch_width_select_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .ready_o(ready_o), .res_valid_o(res_valid_o),
    .res_o(res_o), .mode_o(mode_o), .mode_unsupported_o(mode_unsupported_o),
    .fetch_wide_o(fetch_wide_o));

  // built as shipped: only one mode exists
  cmav_core u_adv (.core_clk_i(core_clk_i), .reset_i(reset_i), .mode_pins_i(mode_pins_i),
    .fetch_width_select_i(fetch_width_select_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .ready_o(), .res_valid_o(), .res_o(), .mode_o(adv_mode),
    .mode_unsupported_o(adv_unsup), .fetch_wide_o());

  cmav_mem_model #(.CODE_BUS_W(CODE_BUS_W)) u_mem (.rd_en_i(mem_en), .addr_i(mem_addr),
    .rd_data_o(mem_data));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed = (seed >> 1) ^ (seed[0] ? 32'h8020_0003 : 32'h0000_0000);
    return seed;
  endfunction : rnd

  function automatic cmav_res_t expect_res(input cmav_mode_t m, input cmav_req_t r);
    cmav_res_t   e;
    logic [31:0] pm;
    logic        n;
    n  = (m == CMAV_MODE_NORMAL);
    pm = n ? 32'h0000_FFFF : (m == CMAV_MODE_MAXIMUM) ? 32'hFFFF_FFFF : 32'h00FF_FFFF;
    e  = '0;
    case (r.kind)
      CMAV_K_DATA_EA: e.addr = n ? {16'h0000, r.value[15:0]} : (m == CMAV_MODE_MIDDLE) ?
        {8'h00, {8{r.value[15]}}, r.value[15:0]} : r.value;
      CMAV_K_VEC_ADDR: e.addr = {25'h000_0000, r.aux[6:0]} << (n ? 1 : 2);
      CMAV_K_IND_ADDR: e.addr = {24'h00_0000, r.aux};
      CMAV_K_PTR_STEP: e.addr = r.aux[3] ? r.value - {29'h0000_0000, r.aux[2:0]} :
        r.value + {29'h0000_0000, r.aux[2:0]};
      CMAV_K_STACK_PC: begin
        e.addr     = r.value & pm;
        e.pc_bytes = n ? 3'h2 : (m == CMAV_MODE_MAXIMUM) ? 3'h4 : 3'h3;
        e.push_ext_ctl = r.aux[0] & (r.aux[1] | (m == CMAV_MODE_MAXIMUM));
      end
      default: e.addr = r.value & pm;
    endcase
    return e;
  endfunction : expect_res

  task automatic send(input cmav_mode_t m, input cmav_kind_t k, input logic [31:0] v,
                      input logic [7:0] a);
    req_i       = '{kind: k, value: v, aux: a};
    req_valid_i = 1'b1;
    last_exp    = expect_res(m, req_i);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("res_valid", 32'h0000_0001, {31'h0000_0000, res_valid_o});
    chk("addr", last_exp.addr, res_o.addr);
    chk("pc_bytes", {29'h0000_0000, last_exp.pc_bytes},
        {29'h0000_0000, res_o.pc_bytes});
    chk("push_ext_ctl", {31'h0000_0000, last_exp.push_ext_ctl},
        {31'h0000_0000, res_o.push_ext_ctl});
  endtask : send

  // branch target read back from the memory model at the address just formed
  task automatic via_mem(input cmav_mode_t m, input cmav_kind_t k);
    mem_addr = res_o.addr;
    mem_en   = 1'b1;
    #1;
    send(m, k, mem_data, 8'h00);
    mem_en   = 1'b0;
  endtask : via_mem

  // a request is held up through reset so that its refusal is seen
  task automatic restart(input logic [1:0] m);
    @(negedge core_clk_i);
    mode_pins_i = m;
    reset_i     = 1'b1;
    req_valid_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk("ready", 32'h0000_0001, {31'h0000_0000, ready_o});
    chk("refused", 32'h0000_0000, {31'h0000_0000, res_valid_o});
    chk("mode", {30'h0000_0000, m}, {30'h0000_0000, mode_o});
    chk("adv_mode", {30'h0000_0000, CMAV_MODE_ADVANCED}, {30'h0000_0000, adv_mode});
    chk("adv_unsup", {31'h0000_0000, m != 2'h2}, {31'h0000_0000, adv_unsup});
    chk("unsup", 32'h0000_0000, {31'h0000_0000, mode_unsupported_o});
  endtask : restart

  task automatic close_out();
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    #100000;
    fails++;
    close_out();
  end

  initial begin
    cmav_mode_t  m;
    logic [31:0] x;
    logic        fw;
    seed    = 32'hA1F1_501C;
    fails   = 0;
    checked = 0;
    reset_i = 1'b1;
    mode_pins_i = 2'h2;
    fetch_width_select_i = (CODE_BUS_W == 32);
    req_valid_i = 1'b0;
    req_i       = '0;
    mem_en      = 1'b0;
    mem_addr    = 32'h0000_0000;
    for (int mi = 0; mi < 4; mi++) begin
      m = cmav_mode_t'(mi[1:0]);
      restart(mi[1:0]);
      send(m, CMAV_K_PTR_STEP, 32'h0000_FFFF, 8'h01);
      send(m, CMAV_K_PTR_STEP, 32'h0001_0000, 8'h0C);
      send(m, CMAV_K_DATA_EA, 32'h1234_8000, 8'h00);
      send(m, CMAV_K_PROG_EA, 32'hFFFF_FFFE, 8'h00);
      send(m, CMAV_K_STACK_PC, 32'hFEDC_BA98, 8'h01);
      send(m, CMAV_K_VEC_ADDR, 32'h0000_0000, 8'h7F);
      via_mem(m, CMAV_K_VEC_TGT);
      send(m, CMAV_K_IND_ADDR, 32'h0000_0000, 8'hFF);
      via_mem(m, CMAV_K_IND_TGT);
      fw = ~fetch_width_select_i;
      fetch_width_select_i = fw;
      send(m, CMAV_K_DATA_EA, 32'h00AB_7FFF, 8'h00);
      chk("fetch_wide", {31'h0000_0000, fw}, {31'h0000_0000, fetch_wide_o});
      fetch_width_select_i = (CODE_BUS_W == 32);
      mode_pins_i = ~mi[1:0];
      for (int i = 0; i < 40; i++) begin
        x = rnd();
        send(m, cmav_kind_t'(x[2:0]), rnd(), x[15:8]);
      end
      req_valid_i = 1'b0;
      @(negedge core_clk_i);
      chk("idle", 32'h0000_0000, {31'h0000_0000, res_valid_o});
      chk("held", last_exp.addr, res_o.addr);
      chk("mode_held", {30'h0000_0000, m}, {30'h0000_0000, mode_o});
    end
    close_out();
  end
endmodule : cmav_core_tb
`default_nettype wire
